/* File: hw/pvp_serial_nvm_program_port.v */
// serial program/verify port: mode entry, command decode, payloads
//
// Behaviour
// - bits travel msb first, change after rise
// - entry resets logic, tristates io, clears pointer
// - high-voltage session ends when low-voltage select pin goes high
// - 32-bit key, 31 compared, last clock enters
// - key shifted msb first, upper 31 bits must match
// - low-voltage session ends when pin goes low
// - key entry only while enable bit set
// - enable bit cleared only in high-voltage session
// - every command is one eight-bit byte
// - payload: start, pads, data msb first, stop
// - 0x80 loads pointer from payload
// - 0x18 bulk erase unless external cycle open, no payload
// - 0xF0 erases row at pointer
// - 0x00/0x02 load latch, bit1 increments
// - 0xFC/0xFE read word, bit1 increments
// - 0xF8 increments pointer
// - 0xE0 starts internally timed programming
// - 0xC0 begins, 0x82 ends external programming
// - host clocks; both sample on falling edge
// - drive on first fall, release after 24th
`timescale 1ns/10ps
`default_nettype none
`include "pvp_consts.vh"

module pvp_serial_nvm_program_port #(
	parameter ADDR_W    = 16,
	parameter DATA_W    = 14,
	// entry key value is arbitrary
	parameter ENTRY_KEY = 32'h5A3C_96E1
) (
	input  wire              i_mclk,
	input  wire              i_resetn,
	input  wire              i_prog_clock_in,
	input  wire              i_prog_data_in,
	input  wire              i_mode_select_low,
	input  wire              i_mode_select_hv,
	input  wire              i_low_voltage_prog_enable,
	input  wire [DATA_W-1:0] i_nvm_rd_data,
	output reg               o_prog_data_out,
	output reg               o_prog_data_oe_n,
	output reg               o_prog_mode,
	output reg               o_hv_session,
	output reg               o_logic_reset_hold,
	output reg               o_io_hiz,
	output reg               o_lvp_clear_allow,
	output wire [ADDR_W-1:0] o_nvm_address_pointer,
	output reg               o_latch_wr,
	output reg  [DATA_W-1:0] o_latch_data,
	output reg               o_bulk_erase,
	output reg               o_row_erase,
	output reg               o_prog_int_start,
	output reg               o_prog_ext_start,
	output reg               o_prog_ext_end
);

	localparam [1:0] ST_CMD  = 2'b00;
	localparam [1:0] ST_WPAY = 2'b01;
	localparam [1:0] ST_RPAY = 2'b10;

	localparam [`PVP_CNT_W-1:0] CNT_ONE = 6'h01;

	// pin synchronisers
	wire [3:0] pins_s;
	wire       clk_s;
	wire       dat_s;
	wire       ms_low_s;
	wire       ms_hv_s;

	pvp_sync #(
		.WIDTH (4)
	) u_sync (
		.i_mclk   (i_mclk),
		.i_resetn (i_resetn),
		.i_async  ({i_mode_select_hv, i_mode_select_low, i_prog_data_in, i_prog_clock_in}),
		.o_sync   (pins_s)
	);

	assign clk_s    = pins_s[0];
	assign dat_s    = pins_s[1];
	assign ms_low_s = pins_s[2];
	assign ms_hv_s  = pins_s[3];

	reg clk_prev_q;
	reg hv_prev_q;

	wire clk_fall = clk_prev_q & ~clk_s;
	wire clk_rise = ~clk_prev_q & clk_s;
	wire hv_rise  = ~hv_prev_q & ms_hv_s;

	// state
	reg [1:0]            st_q;
	reg [1:0]            st_d;
	reg [`PVP_CNT_W-1:0] cnt_q;
	reg [`PVP_CNT_W-1:0] cnt_d;
	reg [31:0]           sh_q;
	reg [31:0]           sh_d;
	reg                  mode_q;
	reg                  mode_d;
	reg                  hv_q;
	reg                  hv_d;
	reg                  ext_busy_q;
	reg                  ext_busy_d;
	reg                  pay_pc_q;
	reg                  pay_pc_d;
	reg                  j_q;
	reg                  j_d;
	reg [23:0]           rd_sh_q;
	reg [23:0]           rd_sh_d;
	reg                  out_d;
	reg                  oe_n_d;

	// one-cycle actions
	reg              ptr_clr;
	reg              ptr_load;
	reg              ptr_inc;
	reg [ADDR_W-1:0] ptr_val;
	reg              latch_wr_d;
	reg [DATA_W-1:0] latch_data_d;
	reg              bulk_d;
	reg              row_d;
	reg              pint_d;
	reg              pext_d;
	reg              pend_d;

	// shifted-in values including the bit just sampled
	reg [31:0] sh_next;
	reg [7:0]  cmd;
	reg [23:0] pay;

	pvp_addr_ptr #(
		.ADDR_W (ADDR_W)
	) u_ptr (
		.i_mclk     (i_mclk),
		.i_resetn   (i_resetn),
		.i_clear    (ptr_clr),
		.i_load     (ptr_load),
		.i_load_val (ptr_val),
		.i_inc      (ptr_inc),
		.o_addr     (o_nvm_address_pointer)
	);

	always @* begin
		sh_next      = {sh_q[30:0], dat_s};
		cmd          = sh_next[7:0];
		pay          = sh_next[23:0];
		st_d         = st_q;
		cnt_d        = cnt_q;
		sh_d         = sh_q;
		mode_d       = mode_q;
		hv_d         = hv_q;
		ext_busy_d   = ext_busy_q;
		pay_pc_d     = pay_pc_q;
		j_d          = j_q;
		rd_sh_d      = rd_sh_q;
		out_d        = o_prog_data_out;
		oe_n_d       = o_prog_data_oe_n;
		ptr_clr      = 1'b0;
		ptr_load     = 1'b0;
		ptr_inc      = 1'b0;
		ptr_val      = pay[`PVP_PAY_DATA_LSB +: ADDR_W];
		latch_wr_d   = 1'b0;
		latch_data_d = o_latch_data;
		bulk_d       = 1'b0;
		row_d        = 1'b0;
		pint_d       = 1'b0;
		pext_d       = 1'b0;
		pend_d       = 1'b0;

		if (!mode_q) begin
			if (hv_rise) begin
				// high-voltage entry, allowed regardless of enable bit
				mode_d = 1'b1;
				hv_d   = 1'b1;
			end else if (ms_low_s && i_low_voltage_prog_enable) begin
				if (clk_fall) begin
					sh_d = sh_next;
					if (cnt_q != `PVP_KEY_BITS)
						cnt_d = cnt_q + CNT_ONE;
					// last bit is a don't-care, its clock enters the mode
					if (cnt_q >= (`PVP_KEY_BITS - CNT_ONE) &&
					    sh_next[31:1] == ENTRY_KEY[31:1]) begin
						mode_d = 1'b1;
						hv_d   = 1'b0;
					end
				end
			end else begin
				cnt_d = {`PVP_CNT_W{1'b0}};
			end
			if (mode_d) begin
				// entry resets pointer, state, counter, shifter and output drive
				ptr_clr    = 1'b1;
				st_d       = ST_CMD;
				cnt_d      = {`PVP_CNT_W{1'b0}};
				sh_d       = 32'h0000_0000;
				ext_busy_d = 1'b0;
				oe_n_d     = 1'b1;
				out_d      = 1'b0;
			end
		end else if ((hv_q && ms_low_s) || (!hv_q && !ms_low_s)) begin
			mode_d     = 1'b0;
			hv_d       = 1'b0;
			st_d       = ST_CMD;
			cnt_d      = {`PVP_CNT_W{1'b0}};
			ext_busy_d = 1'b0;
			oe_n_d     = 1'b1;
			out_d      = 1'b0;
		end else begin
			case (st_q)
				ST_CMD: begin
					if (clk_fall) begin
						sh_d  = sh_next;
						cnt_d = cnt_q + CNT_ONE;
						if (cnt_q == (`PVP_CMD_BITS - CNT_ONE)) begin
							cnt_d = {`PVP_CNT_W{1'b0}};
							j_d   = cmd[`PVP_CMD_J_BIT];
							case (cmd)
								`PVP_CMD_LOAD_PC: begin
									st_d     = ST_WPAY;
									pay_pc_d = 1'b1;
								end
								`PVP_CMD_LOAD_D0, `PVP_CMD_LOAD_D1: begin
									st_d     = ST_WPAY;
									pay_pc_d = 1'b0;
								end
								`PVP_CMD_READ_D0, `PVP_CMD_READ_D1: begin
									st_d    = ST_RPAY;
									rd_sh_d = {1'b0, {`PVP_RD_PAD_BITS{1'b0}}, i_nvm_rd_data, 1'b0};
								end
								`PVP_CMD_BULK_ERA: begin
									// no bulk erase while an external programming cycle is open
									bulk_d = ~ext_busy_q;
								end
								`PVP_CMD_ROW_ERA: begin
									row_d = 1'b1;
								end
								`PVP_CMD_INC_ADDR: begin
									ptr_inc = 1'b1;
								end
								`PVP_CMD_PROG_INT: begin
									pint_d = 1'b1;
								end
								`PVP_CMD_PROG_EXT: begin
									pext_d     = 1'b1;
									ext_busy_d = 1'b1;
								end
								`PVP_CMD_END_EXT: begin
									// nop when no external cycle is open
									pend_d     = ext_busy_q;
									ext_busy_d = 1'b0;
								end
								default: begin
									st_d = ST_CMD;
								end
							endcase
						end
					end
				end
				ST_WPAY: begin
					if (clk_fall) begin
						sh_d  = sh_next;
						cnt_d = cnt_q + CNT_ONE;
						if (cnt_q == (`PVP_PAY_BITS - CNT_ONE)) begin
							cnt_d = {`PVP_CNT_W{1'b0}};
							st_d  = ST_CMD;
							if (pay_pc_q) begin
								ptr_load = 1'b1;
							end else begin
								// framing bits dropped, data sits above stop bit
								latch_wr_d   = 1'b1;
								latch_data_d = pay[`PVP_PAY_DATA_LSB +: DATA_W];
								ptr_inc      = j_q;
							end
						end
					end
				end
				ST_RPAY: begin
					if (clk_fall) begin
						cnt_d = cnt_q + CNT_ONE;
						if (cnt_q == {`PVP_CNT_W{1'b0}}) begin
							oe_n_d = 1'b0;
							out_d  = rd_sh_q[23];
						end
						if (cnt_q == (`PVP_PAY_BITS - CNT_ONE)) begin
							oe_n_d  = 1'b1;
							out_d   = 1'b0;
							cnt_d   = {`PVP_CNT_W{1'b0}};
							st_d    = ST_CMD;
							ptr_inc = j_q;
						end
					end else if (clk_rise && !o_prog_data_oe_n) begin
						// next bit goes out after the host's rising edge
						rd_sh_d = {rd_sh_q[22:0], 1'b0};
						out_d   = rd_sh_q[22];
					end
				end
				default: begin
					st_d  = ST_CMD;
					cnt_d = {`PVP_CNT_W{1'b0}};
				end
			endcase
		end
	end

	always @(posedge i_mclk) begin
		if (!i_resetn) begin
			clk_prev_q       <= 1'b0;
			hv_prev_q        <= 1'b0;
			st_q             <= ST_CMD;
			cnt_q            <= {`PVP_CNT_W{1'b0}};
			sh_q             <= 32'h0000_0000;
			mode_q           <= 1'b0;
			hv_q             <= 1'b0;
			ext_busy_q       <= 1'b0;
			pay_pc_q         <= 1'b0;
			j_q              <= 1'b0;
			rd_sh_q          <= 24'h00_0000;
			o_prog_data_out  <= 1'b0;
			o_prog_data_oe_n <= 1'b1;
			o_prog_mode      <= 1'b0;
			o_hv_session     <= 1'b0;
			o_logic_reset_hold <= 1'b0;
			o_io_hiz         <= 1'b0;
			o_lvp_clear_allow <= 1'b0;
			o_latch_wr       <= 1'b0;
			o_latch_data     <= {DATA_W{1'b0}};
			o_bulk_erase     <= 1'b0;
			o_row_erase      <= 1'b0;
			o_prog_int_start <= 1'b0;
			o_prog_ext_start <= 1'b0;
			o_prog_ext_end   <= 1'b0;
		end else begin
			clk_prev_q       <= clk_s;
			hv_prev_q        <= ms_hv_s;
			st_q             <= st_d;
			cnt_q            <= cnt_d;
			sh_q             <= sh_d;
			mode_q           <= mode_d;
			hv_q             <= hv_d;
			ext_busy_q       <= ext_busy_d;
			pay_pc_q         <= pay_pc_d;
			j_q              <= j_d;
			rd_sh_q          <= rd_sh_d;
			o_prog_data_out  <= out_d;
			o_prog_data_oe_n <= oe_n_d;
			o_prog_mode      <= mode_d;
			o_hv_session     <= mode_d & hv_d;
			o_logic_reset_hold <= mode_d;
			o_io_hiz         <= mode_d;
			o_lvp_clear_allow <= mode_d & hv_d;
			o_latch_wr       <= latch_wr_d;
			o_latch_data     <= latch_data_d;
			o_bulk_erase     <= bulk_d;
			o_row_erase      <= row_d;
			o_prog_int_start <= pint_d;
			o_prog_ext_start <= pext_d;
			o_prog_ext_end   <= pend_d;
		end
	end

endmodule

`default_nettype wire

/* File: hw/pvp_consts.vh */
// constants for the serial nvm program port
`ifndef PVP_CONSTS_VH
`define PVP_CONSTS_VH

`define PVP_CMD_BITS      6'h08
`define PVP_PAY_BITS      6'h18
`define PVP_KEY_BITS      6'h20
`define PVP_CNT_W         6

`define PVP_CMD_LOAD_PC   8'h80
`define PVP_CMD_BULK_ERA  8'h18
`define PVP_CMD_ROW_ERA   8'hF0
`define PVP_CMD_LOAD_D0   8'h00
`define PVP_CMD_LOAD_D1   8'h02
`define PVP_CMD_READ_D0   8'hFC
`define PVP_CMD_READ_D1   8'hFE
`define PVP_CMD_INC_ADDR  8'hF8
`define PVP_CMD_PROG_INT  8'hE0
`define PVP_CMD_PROG_EXT  8'hC0
`define PVP_CMD_END_EXT   8'h82
`define PVP_CMD_J_BIT     1

`define PVP_PAY_DATA_LSB  1
`define PVP_RD_PAD_BITS   8

`endif

/* File: hw/pvp_sync.v */
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none

module pvp_sync #(
	parameter WIDTH = 1
) (
	input  wire             i_mclk,
	input  wire             i_resetn,
	input  wire [WIDTH-1:0] i_async,
	output reg  [WIDTH-1:0] o_sync
);

	reg [WIDTH-1:0] meta_q;

	always @(posedge i_mclk) begin
		if (!i_resetn) begin
			meta_q <= {WIDTH{1'b0}};
			o_sync <= {WIDTH{1'b0}};
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end

endmodule

`default_nettype wire

/* File: hw/pvp_addr_ptr.v */
// auto-incrementing nvm address pointer
`timescale 1ns/10ps
`default_nettype none

module pvp_addr_ptr #(
	parameter ADDR_W = 16
) (
	input  wire              i_mclk,
	input  wire              i_resetn,
	input  wire              i_clear,
	input  wire              i_load,
	input  wire [ADDR_W-1:0] i_load_val,
	input  wire              i_inc,
	output reg  [ADDR_W-1:0] o_addr
);

	// clear beats load beats increment
	always @(posedge i_mclk) begin
		if (!i_resetn) begin
			o_addr <= {ADDR_W{1'b0}};
		end else if (i_clear) begin
			o_addr <= {ADDR_W{1'b0}};
		end else if (i_load) begin
			o_addr <= i_load_val;
		end else if (i_inc) begin
			o_addr <= o_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
		end
	end

endmodule

`default_nettype wire

/* File: testbench/pvp_port_chk.sv */
// assertions on the program port outputs
`timescale 1ns/10ps
`default_nettype none
module pvp_port_chk #(
	parameter ADDR_W = 16
) (
	input wire logic              i_mclk,
	input wire logic              i_resetn,
	input wire logic              o_prog_data_out,
	input wire logic              o_prog_data_oe_n,
	input wire logic              o_prog_mode,
	input wire logic              o_hv_session,
	input wire logic              o_logic_reset_hold,
	input wire logic              o_io_hiz,
	input wire logic              o_lvp_clear_allow,
	input wire logic [ADDR_W-1:0] o_nvm_address_pointer,
	input wire logic              o_latch_wr,
	input wire logic              o_bulk_erase,
	input wire logic              o_row_erase,
	input wire logic              o_prog_int_start,
	input wire logic              o_prog_ext_start,
	input wire logic              o_prog_ext_end
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	wire  any_p = o_latch_wr | o_bulk_erase | o_row_erase | o_prog_int_start | o_prog_ext_start | o_prog_ext_end;
	logic ext_open_q;
	// external cycle open between start and end pulses
	always @(posedge i_mclk) begin
		if (!i_resetn || !o_prog_mode || o_prog_ext_end)
			ext_open_q <= 1'b0;
		else if (o_prog_ext_start)
			ext_open_q <= 1'b1;
	end
	mode_mirror_a: assert property (o_logic_reset_hold == o_prog_mode && o_io_hiz == o_prog_mode)
		else $error("reset hold or hiz differs from mode");
	clear_allow_a: assert property (o_lvp_clear_allow == (o_prog_mode && o_hv_session))
		else $error("clear allow wrong");
	entry_clear_a: assert property ($rose(o_prog_mode) |-> ##[0:1] o_nvm_address_pointer == '0)
		else $error("pointer not cleared on entry");
	idle_ptr_a: assert property (!o_prog_mode && !$past(o_prog_mode) |-> $stable(o_nvm_address_pointer))
		else $error("pointer moved outside mode");
	pulse_mode_a: assert property (any_p |-> o_prog_mode && $past(o_prog_mode))
		else $error("pulse outside mode");
	read_drive_a: assert property ($fell(o_prog_data_oe_n) |-> !o_prog_data_out ##1 (!o_prog_data_oe_n)[*8])
		else $error("read drive too short");
	release_low_a: assert property (o_prog_data_oe_n || !o_prog_mode |-> o_prog_data_oe_n && !o_prog_data_out)
		else $error("pin driven when released");
	ext_pair_a: assert property (o_prog_ext_end |-> ext_open_q)
		else $error("end without start");
endmodule
bind pvp_serial_nvm_program_port pvp_port_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

/* File: testbench/pvp_host_model.sv */
// host programmer model driving clock and data pins
`timescale 1ns/10ps
`default_nettype none
module pvp_host_model (
	output logic        o_clk,
	output logic        o_dat,
	input  wire logic   i_pin,
	output logic [23:0] o_rd
);
	initial begin
		o_clk = 1'b0;
		o_dat = 1'b0;
		o_rd = 24'h000000;
	end
	// clock stands low between frames; released line toggles
	task automatic xfer(input int n, input logic [31:0] v, input logic rd);
		for (int i = n - 1; i >= 0; i--) begin
			#62.5 o_clk = 1'b1;
			o_dat = rd ? ~o_dat : v[i];
			#62.5 o_rd = {o_rd[22:0], i_pin};
			o_clk = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// testbench for the serial program port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	// arbitrary key value
	localparam logic [31:0] KEY = 32'hC3A5_0F96;
	logic        i_mclk, i_resetn, i_prog_clock_in, host_dat;
	logic        i_mode_select_low, i_mode_select_hv, i_low_voltage_prog_enable;
	logic        o_prog_data_out, o_prog_data_oe_n, o_prog_mode, o_hv_session, o_logic_reset_hold, o_io_hiz;
	logic        o_lvp_clear_allow, o_latch_wr, o_bulk_erase, o_row_erase;
	logic        o_prog_int_start, o_prog_ext_start, o_prog_ext_end;
	logic [13:0] i_nvm_rd_data, o_latch_data;
	logic [15:0] o_nvm_address_pointer, p;
	logic [23:0] rd_seen;
	logic [31:0] seed = 32'h7446, a, d;
	logic [5:0]  exp_q[$];
	logic [7:0]  cl[8] = '{8'h18, 8'hF0, 8'hE0, 8'hC0, 8'h18, 8'h82, 8'h55, 8'h82};
	logic [5:0]  pl[8] = '{6'h10, 6'h08, 6'h04, 6'h02, 6'h00, 6'h01, 6'h00, 6'h00};
	int          errors, samples_checked, cyc;
	wire         i_prog_data_in = !o_prog_data_oe_n ? o_prog_data_out : host_dat;
	wire  [5:0]  pv = {o_latch_wr, o_bulk_erase, o_row_erase, o_prog_int_start, o_prog_ext_start, o_prog_ext_end};
	pvp_serial_nvm_program_port #(.ENTRY_KEY(KEY)) u_dut (.*);
	pvp_host_model u_host (.o_clk(i_prog_clock_in), .o_dat(host_dat), .i_pin(i_prog_data_in), .o_rd(rd_seen));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic entry(input logic [31:0] k, input logic en, input logic exp);
		@(negedge i_mclk) i_low_voltage_prog_enable = en;
		u_host.xfer(32, k, 1'b0);
		#200 chk("mode", o_prog_mode, exp);
	endtask
	// np: 0 none, 1 write payload, 2 read payload
	task automatic cmd(input logic [7:0] c, input logic [5:0] v, input logic [31:0] pay, input int np);
		if (v != 6'h00)
			exp_q.push_back(v);
		u_host.xfer(8, {24'h0, c}, 1'b0);
		#300;
		if (np > 0)
			u_host.xfer(24, pay, np == 2);
		#300;
	endtask
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	always @(negedge i_mclk) begin
		cyc++;
		if (|pv)
			chk("pulse", pv, exp_q.size() ? exp_q.pop_front() : 6'h00);
		if (cyc == 20000) begin
			errors++;
			give_verdict();
		end
	end
	initial begin
		{i_resetn, i_mode_select_low, i_mode_select_hv, i_low_voltage_prog_enable} = 4'h0;
		i_nvm_rd_data = 14'h0000;
		repeat (6) @(negedge i_mclk);
		i_resetn = 1'b1;
		repeat (4) @(negedge i_mclk);
		chk("oe_n", o_prog_data_oe_n, 1'b1);
		i_mode_select_low = 1'b1;
		entry(KEY, 1'b0, 1'b0);
		entry(KEY ^ 32'h100, 1'b1, 1'b0);
		entry(KEY ^ 32'h1, 1'b1, 1'b1);
		chk("lv", {o_hv_session, o_lvp_clear_allow, o_io_hiz, o_nvm_address_pointer}, 19'h10000);
		a = rnd();
		d = rnd();
		p = a[15:0];
		cmd(8'h80, 6'h00, {p, 1'b0}, 1);
		chk("ptr", o_nvm_address_pointer, p);
		cmd(8'h02, 6'h20, {d[13:0], 1'b0}, 1);
		p++;
		chk("latch", {o_latch_data, o_nvm_address_pointer}, {d[13:0], p});
		cmd(8'h00, 6'h20, {~d[13:0], 1'b0}, 1);
		chk("latch", {o_latch_data, o_nvm_address_pointer}, {~d[13:0], p});
		cmd(8'hF8, 6'h00, 0, 0);
		p++;
		chk("ptr", o_nvm_address_pointer, p);
		@(negedge i_mclk) i_nvm_rd_data = d[27:14];
		cmd(8'hFE, 6'h00, 0, 2);
		p++;
		chk("read", {rd_seen[14:1], o_nvm_address_pointer}, {d[27:14], p});
		@(negedge i_mclk) i_nvm_rd_data = ~d[27:14];
		cmd(8'hFC, 6'h00, 0, 2);
		chk("read", {rd_seen[14:1], o_nvm_address_pointer}, {~d[27:14], p});
		for (int i = 0; i < 8; i++)
			cmd(cl[i], pl[i], 0, 0);
		chk("ptr", o_nvm_address_pointer, p);
		@(negedge i_mclk) i_mode_select_low = 1'b0;
		#200 chk("mode", o_prog_mode, 1'b0);
		@(negedge i_mclk) i_mode_select_hv = 1'b1;
		#200 chk("hv", {o_prog_mode, o_hv_session, o_lvp_clear_allow, o_nvm_address_pointer}, 19'h70000);
		@(negedge i_mclk) {i_mode_select_hv, i_mode_select_low} = 2'b01;
		#200 chk("mode", o_prog_mode, 1'b0);
		chk("queue", exp_q.size(), 0);
		give_verdict();
	end
endmodule
`default_nettype wire
